//--- rat_alias_table.sv
// remote target alias entries 3 to 6 with wishbone access and remap
`timescale 1ns/10ps

module rat_alias_table (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // wishbone
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic             wb_ack_o,
  output logic [31:0]      wb_dat_o,
  // target addresses, port 1 in bits 55:28, entry 3 lowest
  input  wire logic [55:0] target_addr_i,
  // local transaction from the two-wire host
  input  wire logic        txn_valid_i,
  input  wire logic        txn_port_i,
  input  wire logic [6:0]  txn_addr_i,
  input  wire logic        txn_rd_i,
  // transaction towards the control channel
  output logic             fwd_valid_o,
  output logic             fwd_port_o,
  output logic [6:0]       fwd_addr_o,
  output logic             fwd_rd_o,
  output logic [1:0]       fwd_slot_o,
  output logic             drop_o,
  // control state
  output logic             second_port_select_o
);

  // ****************************************
  // declarations
  // ****************************************
  rat_reg_if           rif ();
  rat_pkg::rat_table_t alias_q;
  rat_pkg::rat_table_t target_tbl;
  logic                port_sel_q;
  logic [1:0]          stat_slot_q;
  logic                stat_hit_q;
  logic                stat_miss_q;
  logic                stat_port_q;
  logic                wr_en;
  logic [rat_pkg::NUM_SLOTS-1:0] slot_hit;
  logic [7:0]          rdata_d;
  logic                fwd_valid;
  logic                fwd_port;
  logic [6:0]          fwd_addr;
  logic                fwd_rd;
  logic [1:0]          fwd_slot;
  logic                drop;

  // ****************************************
  // bus slave
  // ****************************************
  rat_wb_slave u_wb (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_we_i  (wb_we_i),
    .wb_adr_i (wb_adr_i),
    .wb_sel_i (wb_sel_i),
    .wb_dat_i (wb_dat_i),
    .wb_ack_o (wb_ack_o),
    .wb_dat_o (wb_dat_o),
    .rif      (rif.bus)
  );

  // write strobe, low byte lane only
  assign wr_en = rif.req & rif.we & rif.lane0;

  // ****************************************
  // control register
  // ****************************************
  // second_port_select, the only writable control bit
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_sel_q <= 1'b0;
    end else if (wr_en && rif.idx == rat_pkg::IDX_CTRL) begin
      port_sel_q <= rif.wdata[rat_pkg::CTRL_PORT_BIT];
    end
  end

  assign second_port_select_o = port_sel_q;

  // ****************************************
  // alias entries
  // ****************************************
  for (genvar s = 0; s < rat_pkg::NUM_SLOTS; s++) begin : g_slot
    assign slot_hit[s] =
      (rif.idx == rat_pkg::IDX_ALIAS_3 + 8'(s));

    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        alias_q[0][s] <= rat_pkg::RST_ALIAS;
        alias_q[1][s] <= rat_pkg::RST_ALIAS;
      end else if (wr_en && slot_hit[s]) begin
        alias_q[port_sel_q][s] <= rif.wdata[7:rat_pkg::ALIAS_LSB];
      end
    end

    // target addresses arrive on target_addr_i, seven bits per entry
    assign target_tbl[0][s] = target_addr_i[7*s +: 7];
    assign target_tbl[1][s] = target_addr_i[28 + 7*s +: 7];
  end

  // ****************************************
  // read mux
  // ****************************************
  // read from selected copy
  always_comb begin
    rdata_d = 8'h00;
    rif.hit = 1'b0;
    for (int i = 0; i < rat_pkg::NUM_SLOTS; i++) begin
      if (slot_hit[i]) begin
        rdata_d = {alias_q[port_sel_q][i], 1'b0};
        rif.hit = 1'b1;
      end
    end
    if (rif.idx == rat_pkg::IDX_CTRL) begin
      rdata_d[rat_pkg::CTRL_PORT_BIT] = port_sel_q;
      rif.hit = 1'b1;
    end
    if (rif.idx == rat_pkg::IDX_STATUS) begin
      rdata_d[rat_pkg::STAT_SLOT_LSB +: 2] = stat_slot_q;
      rdata_d[rat_pkg::STAT_HIT_BIT]       = stat_hit_q;
      rdata_d[rat_pkg::STAT_MISS_BIT]      = stat_miss_q;
      rdata_d[rat_pkg::STAT_PORT_BIT]      = stat_port_q;
      rif.hit = 1'b1;
    end
  end

  assign rif.rdata = rdata_d;

  // ****************************************
  // remap engine
  // ****************************************
  // lookup against the alias table of the transaction's port only
  rat_remap u_remap (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .alias_tbl  (alias_q),
    .target_tbl (target_tbl),
    .txn_valid  (txn_valid_i),
    .txn_port   (txn_port_i),
    .txn_addr   (txn_addr_i),
    .txn_rd     (txn_rd_i),
    .fwd_valid  (fwd_valid),
    .fwd_port   (fwd_port),
    .fwd_addr   (fwd_addr),
    .fwd_rd     (fwd_rd),
    .fwd_slot   (fwd_slot),
    .drop       (drop)
  );

  // outputs are flops inside the remap engine
  assign fwd_valid_o = fwd_valid;
  assign fwd_port_o  = fwd_port;
  assign fwd_addr_o  = fwd_addr;
  assign fwd_rd_o    = fwd_rd;
  assign fwd_slot_o  = fwd_slot;
  assign drop_o      = drop;

  // ****************************************
  // status capture
  // ****************************************
  // records the result of the most recent lookup
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_slot_q <= 2'h0;
      stat_hit_q  <= 1'b0;
      stat_miss_q <= 1'b0;
      stat_port_q <= 1'b0;
    end else if (fwd_valid || drop) begin
      stat_slot_q <= fwd_slot;
      stat_hit_q  <= fwd_valid;
      stat_miss_q <= drop;
      stat_port_q <= fwd_port;
    end
  end

endmodule : rat_alias_table

//--- rat_alias_table_properties.sv
// port checker for the alias table
`timescale 1ns/10ps
module rat_alias_table_properties (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rst_n,
  // register bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic        wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  // transaction path
  input wire logic [55:0] target_addr_i,
  input wire logic        txn_valid_i,
  input wire logic        txn_port_i,
  input wire logic [6:0]  txn_addr_i,
  input wire logic        txn_rd_i,
  input wire logic        fwd_valid_o,
  input wire logic        fwd_port_o,
  input wire logic [6:0]  fwd_addr_o,
  input wire logic        fwd_rd_o,
  input wire logic [1:0]  fwd_slot_o,
  input wire logic        drop_o
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // taken bus request and offered transaction
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_txn;
    txn_valid_i;
  endsequence
  chk_ack_next: assert property (s_req |=> wb_ack_o)
    else $error("ack missing");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  chk_bit0_zero: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i >= 32'h0000_01e4
    && wb_adr_i <= 32'h0000_01f0 |-> wb_dat_o[0] == 1'b0)
    else $error("reserved bit read high");
  chk_one_answer: assert property (s_txn |=> fwd_valid_o ^ drop_o)
    else $error("not one answer");
  chk_no_stray: assert property (!txn_valid_i |=> !fwd_valid_o && !drop_o)
    else $error("stray answer");
  chk_zero_drop: assert property (
    txn_valid_i && txn_addr_i == 7'h00 |=> drop_o)
    else $error("zero alias forwarded");
  chk_fields_pass: assert property (s_txn ##1 fwd_valid_o |->
    fwd_port_o == $past(txn_port_i) && fwd_rd_o == $past(txn_rd_i))
    else $error("fields not passed");
  chk_target_sub: assert property (fwd_valid_o |-> fwd_addr_o ==
    7'($past(target_addr_i) >> (fwd_port_o * 28 + fwd_slot_o * 7)))
    else $error("wrong target address");
  chk_drop_addr: assert property (drop_o |-> fwd_addr_o == 7'h00)
    else $error("drop with address");
endmodule : rat_alias_table_properties

bind rat_alias_table rat_alias_table_properties u_chk (.core_clk, .rst_n,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_ack_o, .wb_dat_o,
  .target_addr_i, .txn_valid_i, .txn_port_i, .txn_addr_i, .txn_rd_i,
  .fwd_valid_o, .fwd_port_o, .fwd_addr_o, .fwd_rd_o, .fwd_slot_o, .drop_o);

//--- rat_far_end.sv
// far-end model: remote target addresses and forwarded traffic count
`timescale 1ns/10ps
module rat_far_end (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // forwarded transaction
  input  wire logic        fwd_valid,
  // remote target addresses, port 1 entry 6 set to 7'h01
  output logic      [55:0] target_addr,
  output logic      [15:0] n_seen
);
  assign target_addr = 56'h02_a5d3_96b1_c4e7;
  // count what crossed the channel
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) n_seen <= 16'h0000;
    else if (fwd_valid) n_seen <= n_seen + 16'h0001;
  end
endmodule : rat_far_end

//--- rat_pkg.sv
// constants and types for the remote target alias table
package rat_pkg;

  // ****************************************
  // geometry
  // ****************************************
  localparam int unsigned NUM_PORTS  = 2;  // first and second link port
  localparam int unsigned NUM_SLOTS  = 4;  // alias entries 3 to 6
  localparam int unsigned FIRST_SLOT = 3;  // number of the first entry
  localparam int unsigned ADDR_W     = 7;  // two-wire target address width
  localparam int unsigned IDX_W      = 8;  // register index width
  localparam int unsigned SLOT_W     = 2;  // width of a slot number

  // ****************************************
  // register indices (byte address = 4 * index)
  // ****************************************
  localparam logic [7:0] IDX_ALIAS_3 = 8'h79;
  localparam logic [7:0] IDX_ALIAS_4 = 8'h7a;
  localparam logic [7:0] IDX_ALIAS_5 = 8'h7b;
  localparam logic [7:0] IDX_ALIAS_6 = 8'h7c;
  localparam logic [7:0] IDX_CTRL    = 8'h60;  // port select control
  localparam logic [7:0] IDX_STATUS  = 8'h61;  // last lookup result

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int unsigned ALIAS_LSB     = 1;   // alias in bits 7:1
  localparam int unsigned CTRL_PORT_BIT = 0;   // second_port_select
  localparam int unsigned STAT_SLOT_LSB = 0;   // last slot, bits 1:0
  localparam int unsigned STAT_HIT_BIT  = 2;   // last lookup hit
  localparam int unsigned STAT_MISS_BIT = 3;   // last lookup dropped
  localparam int unsigned STAT_PORT_BIT = 4;   // port of last lookup
  localparam logic [6:0]  RST_ALIAS     = 7'h00;
  localparam logic [6:0]  ALIAS_OFF     = 7'h00; // value that disables

  // ****************************************
  // types
  // ****************************************
  typedef logic [NUM_PORTS-1:0][NUM_SLOTS-1:0][ADDR_W-1:0] rat_table_t;

endpackage : rat_pkg

//--- rat_reg_if.sv
// register access carrier between bus slave and register core
`timescale 1ns/10ps
interface rat_reg_if;
  logic       req;    // one-cycle access strobe
  logic       we;     // write when high
  logic       lane0;  // low byte lane selected
  logic [7:0] idx;    // register index
  logic [7:0] wdata;  // write byte
  logic [7:0] rdata;  // read byte, combinational from core
  logic       hit;    // index is mapped

  modport bus (output req, output we, output lane0, output idx,
               output wdata, input rdata, input hit);
  modport core (input req, input we, input lane0, input idx,
                input wdata, output rdata, output hit);
endinterface : rat_reg_if

//--- rat_remap.sv
// alias lookup and address substitution for local transactions
`timescale 1ns/10ps
module rat_remap (
  // clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  // tables
  input  wire rat_pkg::rat_table_t    alias_tbl,
  input  wire rat_pkg::rat_table_t    target_tbl,
  // local transaction
  input  wire logic                   txn_valid,
  input  wire logic                   txn_port,
  input  wire logic [6:0]             txn_addr,
  input  wire logic                   txn_rd,
  // forwarded transaction
  output logic                        fwd_valid,
  output logic                        fwd_port,
  output logic [6:0]                  fwd_addr,
  output logic                        fwd_rd,
  output logic [1:0]                  fwd_slot,
  output logic                        drop
);

  logic [rat_pkg::NUM_SLOTS-1:0] match;
  logic                          hit_d;
  logic [1:0]                    slot_d;

  // ****************************************
  // per-entry compare
  // ****************************************
  // zero entry never matches
  for (genvar g = 0; g < rat_pkg::NUM_SLOTS; g++) begin : g_cmp
    assign match[g] = (alias_tbl[txn_port][g] != rat_pkg::ALIAS_OFF) &&
                      (alias_tbl[txn_port][g] == txn_addr);
  end

  // lowest matching entry wins when two hold the same alias
  always_comb begin
    hit_d  = 1'b0;
    slot_d = 2'h0;
    for (int i = rat_pkg::NUM_SLOTS - 1; i >= 0; i--) begin
      if (match[i]) begin
        hit_d  = 1'b1;
        slot_d = i[1:0];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fwd_valid <= 1'b0;
      fwd_port  <= 1'b0;
      fwd_addr  <= 7'h00;
      fwd_rd    <= 1'b0;
      fwd_slot  <= 2'h0;
      drop      <= 1'b0;
    end else begin
      fwd_valid <= txn_valid & hit_d;
      drop      <= txn_valid & ~hit_d;
      if (txn_valid) begin
        fwd_port <= txn_port;
        fwd_rd   <= txn_rd;
        fwd_slot <= slot_d;
        fwd_addr <= hit_d ? target_tbl[txn_port][slot_d] : 7'h00;
      end
    end
  end

endmodule : rat_remap

//--- rat_wb_slave.sv
// classic wishbone slave answering in one cycle
`timescale 1ns/10ps
module rat_wb_slave (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // wishbone
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic             wb_ack_o,
  output logic [31:0]      wb_dat_o,
  // register core
  rat_reg_if.bus           rif
);

  logic ack_q;
  logic in_range;

  // ****************************************
  // decode
  // ****************************************
  // only word-aligned addresses below 0x400 may reach a register
  assign in_range  = (wb_adr_i[31:10] == '0) && (wb_adr_i[1:0] == 2'h0);
  assign rif.req   = wb_cyc_i & wb_stb_i & ~ack_q & in_range;
  assign rif.we    = wb_we_i;
  assign rif.lane0 = wb_sel_i[0];
  assign rif.idx   = wb_adr_i[9:2];
  assign rif.wdata = wb_dat_i[7:0];

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
    end
  end

  // read data, zero for unmapped or out-of-range addresses
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_dat_o <= '0;
    end else if (wb_cyc_i && wb_stb_i && !ack_q) begin
      wb_dat_o <= (rif.req && rif.hit) ? {24'h0, rif.rdata} : '0;
    end
  end

  assign wb_ack_o = ack_q;

endmodule : rat_wb_slave

//--- testbench.sv
// self-checking bench for the alias table
`timescale 1ns/10ps
module testbench;
  logic        core_clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0;
  logic        tv = 0, tp = 0, tr = 0, ack, fv, fp, fr, drp, psel;
  logic [31:0] adr = 0, dat = 0, dato;
  logic [3:0]  sel = 0;
  logic [6:0]  ta = 0, fa;
  logic [1:0]  fs;
  logic [55:0] tgt;
  logic [15:0] n_seen;
  logic [6:0]  al [2][4];
  logic [7:0]  q;
  int          n_fail = 0, checks = 0, n_fwd = 0;
  always #2.5 core_clk = ~core_clk;
  rat_alias_table u_dut (.core_clk, .rst_n, .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_ack_o(ack), .wb_dat_o(dato), .target_addr_i(tgt), .txn_valid_i(tv),
    .txn_port_i(tp), .txn_addr_i(ta), .txn_rd_i(tr), .fwd_valid_o(fv),
    .fwd_port_o(fp), .fwd_addr_o(fa), .fwd_rd_o(fr), .fwd_slot_o(fs),
    .drop_o(drp), .second_port_select_o(psel));
  rat_far_end u_far (.core_clk, .rst_n, .fwd_valid(fv),
    .target_addr(tgt), .n_seen(n_seen));
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, exp, input string m);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  // one classic cycle, held until ack is seen at a falling edge
  task automatic bus(input logic w, input logic [7:0] i, d,
                     input logic [3:0] s);
    int k;
    @(posedge core_clk);
    cyc <= 1;
    stb <= 1;
    we  <= w;
    sel <= s;
    adr <= {22'h0, i, 2'b00};
    dat <= {24'h0, d};
    k = 0;
    do begin
      @(negedge core_clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    if (ack !== 1'b1) begin
      n_fail++;
      report_and_stop;
    end
    q = dato[7:0];
    @(posedge core_clk);
    cyc <= 0;
    stb <= 0;
  endtask : bus
  task automatic wr(input logic [7:0] i, d);
    bus(1, i, d, 4'h1);
  endtask : wr
  task automatic rd(input logic [7:0] i, e);
    bus(0, i, 8'h00, 4'h1);
    chk(q, e, "read");
  endtask : rd
  // expected slot: lowest enabled entry holding the alias
  function automatic int look(input logic p, input logic [6:0] a);
    for (int s = 0; s < 4; s++)
      if (al[p][s] != 0 && al[p][s] == a) return s;
    return -1;
  endfunction : look
  task automatic txn(input logic p, input logic [6:0] a);
    int s;
    logic r;
    s = look(p, a);
    r = 1'($urandom);
    @(posedge core_clk);
    tv <= 1;
    tp <= p;
    ta <= a;
    tr <= r;
    @(posedge core_clk);
    tv <= 0;
    @(negedge core_clk);
    chk({fv, drp}, {s >= 0, s < 0}, "answer");
    if (s >= 0) begin
      chk({fp, fr, fs, fa}, {p, r, 2'(s), tgt[p*28+s*7 +: 7]}, "fwd");
      n_fwd++;
    end
  endtask : txn
  initial begin
    logic       p;
    logic [6:0] a, old;
    void'($urandom(32'h6470_0151));
    repeat (4) @(posedge core_clk);
    rst_n <= 1;
    rd(8'h60, 8'h00);
    rd(8'h61, 8'h00);
    for (int i = 0; i < 2; i++) begin
      wr(8'h60, 8'(i));
      for (int s = 0; s < 4; s++) rd(8'h79 + 8'(s), 8'h00);
    end
    $display("test reset values done");
    for (int i = 0; i < 2; i++) begin
      wr(8'h60, 8'(i));
      chk(psel, i[0], "port select");
      for (int s = 0; s < 4; s++) begin
        al[i][s] = 7'($urandom_range(127, 1));
        wr(8'h79 + 8'(s), {al[i][s], 1'b1});
      end
    end
    al[1][3] = al[1][1];
    wr(8'h7c, {al[1][3], 1'b0});
    bus(1, 8'h7b, 8'hff, 4'he);
    for (int i = 0; i < 2; i++) begin
      wr(8'h60, 8'(i));
      for (int s = 0; s < 4; s++) rd(8'h79 + 8'(s), {al[i][s], 1'b0});
    end
    rd(8'h7d, 8'h00);
    $display("test alias access done");
    repeat (60) begin
      p = 1'($urandom);
      a = $urandom_range(1, 0) ? al[p][$urandom_range(3, 0)] : 7'($urandom);
      txn(p, a);
    end
    txn(0, 7'h00);
    txn(1, al[1][3]);
    $display("test remap done");
    old = al[0][0];
    wr(8'h60, 8'h00);
    wr(8'h79, 8'h01);
    al[0][0] = 7'h00;
    txn(0, old);
    chk(n_seen, n_fwd, "forward count");
    $display("test disable done");
    report_and_stop;
  end
  initial begin
    #100000;
    n_fail++;
    report_and_stop;
  end
endmodule : testbench
